// File: shared/agpr_pkg.sv
// Shared constants and types for the pipelined read requester and its bridge end
package agpr_pkg;

	// Outstanding request queue
	localparam int QUEUE_DEPTH = 4;
	localparam int BYTES_W     = 12;

	// Request splitting: reads above the limit go out in fixed chunks
	localparam int SPLIT_LIMIT = 64;
	localparam int CHUNK_BYTES = 32;
	localparam int QW_SHIFT    = 3;
	localparam int QW_BYTES    = 8;

	// Enqueue field layout on the address/data lines
	localparam int ADDR_LSB = 3;
	localparam int LEN_W    = 3;
	localparam int ADDR_W   = 32;
	localparam int CMD_W    = 4;

	// Status codes that travel with the grant
	localparam logic [2:0] STATUS_START = 3'h7;
	localparam logic [2:0] STATUS_NONE  = 3'h0;

	// The only pipelined commands ever issued
	localparam logic [3:0] CMD_READ    = 4'h0;
	localparam logic [3:0] CMD_READ_HI = 4'h1;

	// Idle levels
	localparam logic [31:0] AD_IDLE  = 32'h0000_0000;
	localparam logic [3:0]  CBE_IDLE = 4'hF;

	// Requester sequencer states
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_REQ  = 2'b01,
		DEV_ENQ  = 2'b10,
		DEV_PCI  = 2'b11
	} agpr_dev_state_e;

	// Arbiter states
	typedef enum logic [1:0] {
		HST_IDLE  = 2'b00,
		HST_GRANT = 2'b01,
		HST_BUSY  = 2'b10
	} agpr_hst_state_e;

endpackage : agpr_pkg

// File: shared/agpr_if.sv
// Port wiring between the requester and the bridge arbiter
`timescale 1ns/100ps
interface agpr_if;

	// Bus ownership and pipeline control
	logic        bus_request_n;
	logic        bus_grant_n;
	logic [2:0]  status_code;
	logic        pipe_enqueue_n;
	logic        frame_n;
	// Requester drive of the shared lines
	logic [31:0] dev_ad_out;
	logic        dev_ad_oe;
	logic [3:0]  dev_cbe_out;
	logic        dev_cbe_oe;
	// Resolved shared lines
	logic [31:0] addr_data_bus;
	logic [3:0]  cmd_byte_enable_n;
	// One pulse per completed data reply, oldest first
	logic        reply_done;

	// Shared line levels from the only driver in this scope
	assign addr_data_bus     = dev_ad_oe ? dev_ad_out : agpr_pkg::AD_IDLE;
	assign cmd_byte_enable_n = dev_cbe_oe ? dev_cbe_out : agpr_pkg::CBE_IDLE;

	modport dev (
		output bus_request_n, pipe_enqueue_n, frame_n,
		output dev_ad_out, dev_ad_oe, dev_cbe_out, dev_cbe_oe,
		input  bus_grant_n, status_code, reply_done, addr_data_bus
	);

	modport host (
		input  bus_request_n, pipe_enqueue_n, frame_n,
		input  addr_data_bus, cmd_byte_enable_n,
		output bus_grant_n, status_code, reply_done
	);

endinterface : agpr_if

// File: hw/agpr_slot_count.sv
// Counter of issued requests whose data reply has not yet completed
`timescale 1ns/100ps
module agpr_slot_count #(
	parameter int DEPTH = agpr_pkg::QUEUE_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          sys_rst,
	// Events
	input  wire logic          issue,
	input  wire logic          done,
	// Occupancy
	output logic [CW-1:0]      count_q
);

	logic [CW-1:0] count_d;
	logic          done_ok;

	// A completion with nothing in flight is ignored
	assign done_ok = done && (count_q != '0);
	assign count_d = count_q + CW'(issue) - CW'(done_ok); // see RULE1 see RULE19

	// Occupancy register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule : agpr_slot_count

// File: hw/agpr_requester.sv
// Requester end: asks for the bus and enqueues pipelined memory reads
// Behaviour
// RULE1: At most four requests outstanding, tracked.
// RULE2: Only normal and high-priority reads issued.
// RULE3: Reads above 64 bytes split into 32-byte pieces.
// RULE4: Stall risk selects high priority read.
// RULE5: Request bus before any request or transaction.
// RULE6: Arbiter grants with status start pattern.
// RULE7: Begin within two clocks after start grant.
// RULE8: One request captured per enqueue clock.
// RULE9: Address, length, command on fixed lines.
// RULE10: Last request: enqueue with request deasserted.
// RULE11: Drop enqueue clock after request seen deasserted.
// RULE12: Keep requesting while more requests and slots.
// RULE13: Arbiter drops grant after enqueue or frame.
// RULE14: PCI transactions may interleave with replies.
// RULE15: Start grant permits requests, not data.
// RULE16: Back-to-back enqueue; insert requests during replies.
// RULE17: Pipelined requests target system memory only.
// RULE18: No reserved fields, encodings or pins used.
// RULE19: Stop issuing at four; oldest reply frees.
`timescale 1ns/100ps
module agpr_requester #(
	parameter int QDEPTH  = agpr_pkg::QUEUE_DEPTH,
	parameter int BYTES_W = agpr_pkg::BYTES_W,
	parameter int CW      = $clog2(QDEPTH + 1)
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// Port towards the bridge
	agpr_if.dev                     port,
	// Memory read requests from the render engine
	input  wire logic               rd_valid,
	input  wire logic [31:0]        rd_addr,
	input  wire logic [BYTES_W-1:0] rd_bytes,
	input  wire logic               rd_stall_risk,
	output logic                    rd_ready,
	// PCI transaction requests
	input  wire logic               pci_valid,
	output logic                    pci_ready,
	output logic                    pci_start,
	// Requests in flight
	output logic [CW-1:0]           outstanding
);

	// Sequencer and pin registers
	agpr_pkg::agpr_dev_state_e state_q, state_d;
	logic                      req_n_q, req_n_d;
	logic                      pipe_n_q, pipe_n_d;
	logic                      frame_n_q, frame_n_d;
	logic [31:0]               ad_q, ad_d;
	logic [3:0]                cbe_q, cbe_d;
	logic                      oe_q, oe_d;
	logic                      pci_start_q, pci_start_d;
	logic                      kind_pci_q, kind_pci_d;

	// Pending work
	logic                      job_busy_q;
	logic [31:0]               job_addr_q;
	logic [BYTES_W-1:0]        job_left_q;
	logic                      job_hi_q;
	logic                      job_split_q;
	logic                      rd_ready_q;
	logic                      pci_pend_q;
	logic                      pci_ready_q;

	// Decode of the next piece
	logic [BYTES_W-1:0]        rd_qw_bytes;
	logic [BYTES_W-1:0]        rd_len_bytes;
	logic                      rd_split;
	logic [BYTES_W-1:0]        piece_bytes;
	logic [BYTES_W-1:0]        piece_qw;
	logic [2:0]                piece_len;
	logic [3:0]                piece_cmd;
	logic [31:0]               piece_word;
	logic                      piece_final;
	logic                      slot_last;
	logic                      can_issue;
	logic                      piece_last;
	logic                      start_seen;
	logic                      rd_take;
	logic                      pci_take;
	logic                      issue;
	logic [CW-1:0]             count;

	// In-flight tracking; a completed reply frees the oldest slot
	agpr_slot_count #(
		.DEPTH   (QDEPTH),
		.CW      (CW)
	) u_slots (
		.clock   (clock),
		.sys_rst (sys_rst),
		.issue   (issue),
		.done    (port.reply_done),
		.count_q (count)
	);

	// Request acceptance; length is cut to whole quadwords, zero taken as one
	assign rd_take      = rd_valid && rd_ready_q;
	assign pci_take     = pci_valid && pci_ready_q;
	assign rd_qw_bytes  = rd_bytes & ~BYTES_W'(agpr_pkg::QW_BYTES - 1);
	assign rd_len_bytes = (rd_qw_bytes == '0) ? BYTES_W'(agpr_pkg::QW_BYTES) : rd_qw_bytes;
	assign rd_split     = rd_len_bytes > BYTES_W'(agpr_pkg::SPLIT_LIMIT); // see RULE3

	// Piece size: a long read goes out wholly as chunks, the tail never merged
	assign piece_bytes = (job_split_q && (job_left_q > BYTES_W'(agpr_pkg::CHUNK_BYTES))) ?
		BYTES_W'(agpr_pkg::CHUNK_BYTES) : job_left_q; // see RULE3
	assign piece_qw    = (piece_bytes >> agpr_pkg::QW_SHIFT) - BYTES_W'(1);
	assign piece_len   = piece_qw[agpr_pkg::LEN_W-1:0];

	// Only the two read commands exist here, both to system memory
	assign piece_cmd = job_hi_q ? agpr_pkg::CMD_READ_HI : agpr_pkg::CMD_READ; // see RULE2 see RULE4
	// Address on the upper lines, length code on the lowest three
	assign piece_word = {job_addr_q[agpr_pkg::ADDR_W-1:agpr_pkg::ADDR_LSB], piece_len}; // see RULE9

	// Last piece of this bus operation: job ends or queue fills
	assign piece_final = (job_left_q == piece_bytes);
	assign slot_last   = (count + CW'(1)) >= CW'(QDEPTH); // see RULE12
	assign piece_last  = piece_final || slot_last;
	assign can_issue   = count < CW'(QDEPTH); // see RULE19

	// Start status with grant only opens a request or transaction
	assign start_seen = !port.bus_grant_n && (port.status_code == agpr_pkg::STATUS_START); // see RULE15

	// Sequencer next state
	always_comb begin
		state_d     = state_q;
		req_n_d     = req_n_q;
		pipe_n_d    = 1'b1;
		frame_n_d   = 1'b1;
		ad_d        = agpr_pkg::AD_IDLE;
		cbe_d       = agpr_pkg::CBE_IDLE;
		oe_d        = 1'b0;
		pci_start_d = 1'b0;
		kind_pci_d  = kind_pci_q;
		issue       = 1'b0;
		case (state_q)
			agpr_pkg::DEV_IDLE: begin
				// PCI work first so it can slip in between replies
				if (pci_pend_q) begin
					kind_pci_d = 1'b1;
					req_n_d    = 1'b0; // see RULE5 see RULE14
					state_d    = agpr_pkg::DEV_REQ;
				end else if (job_busy_q && can_issue) begin
					kind_pci_d = 1'b0;
					req_n_d    = 1'b0; // see RULE5 see RULE16
					state_d    = agpr_pkg::DEV_REQ;
				end
			end
			agpr_pkg::DEV_REQ: begin
				// Act on the clock right after the start grant
				if (start_seen && kind_pci_q) begin
					frame_n_d   = 1'b0; // see RULE7
					req_n_d     = 1'b1;
					pci_start_d = 1'b1;
					state_d     = agpr_pkg::DEV_PCI;
				end else if (start_seen) begin
					issue    = 1'b1;
					pipe_n_d = 1'b0; // see RULE7 see RULE8
					ad_d     = piece_word;
					cbe_d    = piece_cmd;
					oe_d     = 1'b1;
					req_n_d  = piece_last; // see RULE10
					state_d  = agpr_pkg::DEV_ENQ;
				end
			end
			agpr_pkg::DEV_ENQ: begin
				if (req_n_q) begin
					// Request was seen deasserted: enqueue ends now
					state_d = agpr_pkg::DEV_IDLE; // see RULE11
				end else begin
					// Back-to-back enqueue of the next piece
					issue    = 1'b1;
					pipe_n_d = 1'b0; // see RULE12 see RULE16
					ad_d     = piece_word;
					cbe_d    = piece_cmd;
					oe_d     = 1'b1;
					req_n_d  = piece_last; // see RULE10
				end
			end
			agpr_pkg::DEV_PCI: begin
				// Single-clock address phase, then the bus is released
				state_d = agpr_pkg::DEV_IDLE;
			end
			default: begin
				state_d = agpr_pkg::DEV_IDLE;
				req_n_d = 1'b1;
			end
		endcase
	end

	// Sequencer and pin registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q     <= agpr_pkg::DEV_IDLE;
			req_n_q     <= 1'b1;
			pipe_n_q    <= 1'b1;
			frame_n_q   <= 1'b1;
			ad_q        <= agpr_pkg::AD_IDLE;
			cbe_q       <= agpr_pkg::CBE_IDLE;
			oe_q        <= 1'b0;
			pci_start_q <= 1'b0;
			kind_pci_q  <= 1'b0;
		end else begin
			state_q     <= state_d;
			req_n_q     <= req_n_d;
			pipe_n_q    <= pipe_n_d;
			frame_n_q   <= frame_n_d;
			ad_q        <= ad_d;
			cbe_q       <= cbe_d;
			oe_q        <= oe_d;
			pci_start_q <= pci_start_d;
			kind_pci_q  <= kind_pci_d;
		end
	end

	// Read job: loaded when idle, walked forward one piece per issue
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			job_busy_q <= 1'b0;
			job_addr_q <= agpr_pkg::AD_IDLE;
			job_left_q <= '0;
			job_hi_q   <= 1'b0;
			job_split_q <= 1'b0;
			rd_ready_q <= 1'b0;
		end else if (rd_take) begin
			job_busy_q <= 1'b1;
			job_split_q <= rd_split; // see RULE3
			job_addr_q <= rd_addr;
			job_left_q <= rd_len_bytes;
			job_hi_q   <= rd_stall_risk; // see RULE4
			rd_ready_q <= 1'b0;
		end else if (issue) begin
			job_addr_q <= job_addr_q + 32'(piece_bytes); // see RULE3
			job_left_q <= job_left_q - piece_bytes;
			job_busy_q <= !piece_final;
			rd_ready_q <= piece_final;
		end else begin
			rd_ready_q <= !job_busy_q;
		end
	end

	// PCI request hand-off: one pending at a time
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pci_pend_q  <= 1'b0;
			pci_ready_q <= 1'b0;
		end else if (pci_take) begin
			pci_pend_q  <= 1'b1;
			pci_ready_q <= 1'b0;
		end else if (pci_start_d) begin
			pci_pend_q  <= 1'b0;
		end else begin
			pci_ready_q <= !pci_pend_q;
		end
	end

	// Pins; lines carry only defined fields and read commands
	assign port.bus_request_n  = req_n_q;
	assign port.pipe_enqueue_n = pipe_n_q;
	assign port.frame_n        = frame_n_q;
	assign port.dev_ad_out     = ad_q;
	assign port.dev_ad_oe      = oe_q; // see RULE18
	assign port.dev_cbe_out    = cbe_q;
	assign port.dev_cbe_oe     = oe_q; // see RULE17

	// User-side status
	assign rd_ready    = rd_ready_q;
	assign pci_ready   = pci_ready_q;
	assign pci_start   = pci_start_q;
	assign outstanding = count; // see RULE1

endmodule : agpr_requester

// File: hw/agpr_bridge_end.sv
// Bridge end: arbiter that grants the port and captures enqueued requests
`timescale 1ns/100ps
module agpr_bridge_end (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Port towards the requester
	agpr_if.host             port,
	// Reply completion from the memory side
	input  wire logic        reply_complete,
	// Captured requests
	output logic             cap_valid,
	output logic [31:0]      cap_addr,
	output logic [2:0]       cap_len,
	output logic [3:0]       cap_cmd,
	output logic             cap_last,
	// PCI transaction seen
	output logic             pci_seen
);

	agpr_pkg::agpr_hst_state_e state_q, state_d;
	logic                      grant_n_q, grant_n_d;
	logic [2:0]                status_q, status_d;
	logic                      reply_q;
	logic                      cap_valid_q;
	logic [31:0]               cap_addr_q;
	logic [2:0]                cap_len_q;
	logic [3:0]                cap_cmd_q;
	logic                      cap_last_q;
	logic                      pci_seen_q;
	logic                      enq_seen;
	logic                      frame_seen;

	assign enq_seen   = !port.pipe_enqueue_n;
	assign frame_seen = !port.frame_n;

	// Arbiter next state
	always_comb begin
		state_d   = state_q;
		grant_n_d = grant_n_q;
		status_d  = status_q;
		case (state_q)
			agpr_pkg::HST_IDLE: begin
				if (!port.bus_request_n) begin
					grant_n_d = 1'b0; // see RULE6
					status_d  = agpr_pkg::STATUS_START;
					state_d   = agpr_pkg::HST_GRANT;
				end
			end
			agpr_pkg::HST_GRANT: begin
				if (enq_seen || frame_seen) begin
					grant_n_d = 1'b1; // see RULE13
					status_d  = agpr_pkg::STATUS_NONE;
					state_d   = agpr_pkg::HST_BUSY;
				end
			end
			agpr_pkg::HST_BUSY: begin
				// Wait for the bus to go quiet; replies and PCI may interleave
				if (!enq_seen && !frame_seen) begin
					state_d = agpr_pkg::HST_IDLE; // see RULE14
				end
			end
			default: begin
				state_d   = agpr_pkg::HST_IDLE;
				grant_n_d = 1'b1;
				status_d  = agpr_pkg::STATUS_NONE;
			end
		endcase
	end

	// Arbiter registers and reply completion
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q   <= agpr_pkg::HST_IDLE;
			grant_n_q <= 1'b1;
			status_q  <= agpr_pkg::STATUS_NONE;
			reply_q   <= 1'b0;
		end else begin
			state_q   <= state_d;
			grant_n_q <= grant_n_d;
			status_q  <= status_d;
			reply_q   <= reply_complete;
		end
	end

	// Capture one request on every enqueue clock
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cap_valid_q <= 1'b0;
			cap_addr_q  <= agpr_pkg::AD_IDLE;
			cap_len_q   <= '0;
			cap_cmd_q   <= '0;
			cap_last_q  <= 1'b0;
			pci_seen_q  <= 1'b0;
		end else begin
			cap_valid_q <= enq_seen; // see RULE8
			pci_seen_q  <= frame_seen;
			if (enq_seen) begin
				cap_addr_q <= {port.addr_data_bus[agpr_pkg::ADDR_W-1:agpr_pkg::ADDR_LSB],
					3'h0};
				cap_len_q  <= port.addr_data_bus[agpr_pkg::LEN_W-1:0];
				cap_cmd_q  <= port.cmd_byte_enable_n;
				cap_last_q <= port.bus_request_n;
			end
		end
	end

	// Pins and user outputs
	assign port.bus_grant_n = grant_n_q;
	assign port.status_code = status_q;
	assign port.reply_done  = reply_q;
	assign cap_valid        = cap_valid_q;
	assign cap_addr         = cap_addr_q;
	assign cap_len          = cap_len_q;
	assign cap_cmd          = cap_cmd_q;
	assign cap_last         = cap_last_q;
	assign pci_seen         = pci_seen_q;

endmodule : agpr_bridge_end

// File: test/agpr_checker.sv
// Port protocol checker watching the requester and bridge interface
`timescale 1ns/100ps
module agpr_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// Interface signals
	input wire logic        bus_request_n,
	input wire logic        bus_grant_n,
	input wire logic [2:0]  status_code,
	input wire logic        pipe_enqueue_n,
	input wire logic        frame_n,
	input wire logic        dev_ad_oe,
	input wire logic        dev_cbe_oe,
	input wire logic [3:0]  cmd_byte_enable_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Grant and ownership
	a_grant_start:
	assert property (!bus_grant_n |-> status_code == 3'h7) else $error("grant without start");
	a_req_first:
	assert property ($fell(pipe_enqueue_n) |-> !$past(bus_request_n)) else $error("enqueue unasked");
	a_frame_req:
	assert property ($fell(frame_n) |-> !$past(bus_request_n)) else $error("frame unasked");
	a_start_prompt:
	assert property ($fell(bus_grant_n) |=> !pipe_enqueue_n || !frame_n) else $error("late start");
	a_only_granted:
	assert property ($fell(pipe_enqueue_n) |-> !$past(bus_grant_n) && $past(status_code) == 3'h7)
		else $error("enqueue without grant");
	a_grant_drop:
	assert property (!bus_grant_n && (!pipe_enqueue_n || !frame_n) |=> bus_grant_n)
		else $error("grant held");
	// Enqueue and frame cycles
	a_enq_fields:
	assert property (!pipe_enqueue_n |-> dev_ad_oe && dev_cbe_oe && frame_n)
		else $error("lines not driven");
	a_read_cmds:
	assert property (!pipe_enqueue_n |-> cmd_byte_enable_n == 4'h0 || cmd_byte_enable_n == 4'h1)
		else $error("bad command");
	a_last_drop:
	assert property (!pipe_enqueue_n && bus_request_n |=> pipe_enqueue_n && !dev_ad_oe)
		else $error("enqueue after last");
	a_burst_cont:
	assert property (!pipe_enqueue_n && !bus_request_n |=> !pipe_enqueue_n)
		else $error("burst cut");
	a_queue_cap:
	assert property (!pipe_enqueue_n [*4] |=> pipe_enqueue_n) else $error("over four queued");
	a_frame_pulse:
	assert property (!frame_n |-> bus_request_n ##1 frame_n) else $error("frame too long");
endmodule : agpr_checker

// File: test/agpr_pipelined_read_requester_tb.sv
// Testbench joining the requester and bridge ends through their interface
`timescale 1ns/100ps
module agpr_pipelined_read_requester_tb;
	logic        clock;
	logic        sys_rst;
	logic        rd_valid;
	logic [31:0] rd_addr;
	logic [11:0] rd_bytes;
	logic        rd_stall_risk;
	logic        rd_ready;
	logic        pci_valid;
	logic        pci_ready;
	logic        pci_start;
	logic [2:0]  outstanding;
	logic        reply_complete;
	logic        cap_valid;
	logic [31:0] cap_addr;
	logic [2:0]  cap_len;
	logic [3:0]  cap_cmd;
	logic        cap_last;
	logic        pci_seen;
	int          n_fail;
	int          check_count;
	int          cycles;
	int          pci_n;
	int          pst_n;
	logic [36:0] wq[$];
	logic [39:0] cq[$];

	agpr_if agpr_if_i ();

	agpr_requester agpr_requester_i (.clock(clock), .sys_rst(sys_rst), .port(agpr_if_i.dev),
		.rd_valid(rd_valid), .rd_addr(rd_addr), .rd_bytes(rd_bytes),
		.rd_stall_risk(rd_stall_risk), .rd_ready(rd_ready), .pci_valid(pci_valid),
		.pci_ready(pci_ready), .pci_start(pci_start), .outstanding(outstanding));

	agpr_bridge_end agpr_bridge_end_i (.clock(clock), .sys_rst(sys_rst), .port(agpr_if_i.host),
		.reply_complete(reply_complete), .cap_valid(cap_valid), .cap_addr(cap_addr),
		.cap_len(cap_len), .cap_cmd(cap_cmd), .cap_last(cap_last), .pci_seen(pci_seen));

	agpr_checker agpr_checker_i (.clock(clock), .sys_rst(sys_rst),
		.bus_request_n(agpr_if_i.bus_request_n), .bus_grant_n(agpr_if_i.bus_grant_n),
		.status_code(agpr_if_i.status_code), .pipe_enqueue_n(agpr_if_i.pipe_enqueue_n),
		.frame_n(agpr_if_i.frame_n), .dev_ad_oe(agpr_if_i.dev_ad_oe),
		.dev_cbe_oe(agpr_if_i.dev_cbe_oe), .cmd_byte_enable_n(agpr_if_i.cmd_byte_enable_n));

	// Clock at 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Wire and capture monitors, plus the hang limit
	always @(posedge clock) begin
		if (agpr_if_i.pipe_enqueue_n === 1'b0)
			wq.push_back({agpr_if_i.addr_data_bus, agpr_if_i.cmd_byte_enable_n,
				agpr_if_i.bus_request_n});
		if (cap_valid === 1'b1)
			cq.push_back({cap_addr, cap_len, cap_cmd, cap_last});
		if (pci_seen === 1'b1)
			pci_n++;
		if (pci_start === 1'b1)
			pst_n++;
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end

	task check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wait_cap(input int k);
		int i;
		i = 0;
		while (cq.size() < k && i < 100) begin
			@(negedge clock);
			i++;
		end
	endtask : wait_cap

	// Reply completions, one pulse each, then let the count settle
	task reply(input int k);
		repeat (k) begin
			reply_complete = 1'b1;
			@(negedge clock);
			reply_complete = 1'b0;
			@(negedge clock);
		end
		repeat (3) @(negedge clock);
	endtask : reply

	// One read job, then the wire and the captures compared piece by piece
	task run_job(input logic [31:0] addr, input logic [11:0] bytes, input logic stall);
		int          n;
		int          i;
		logic [2:0]  len;
		logic [31:0] a;
		logic [3:0]  cmd;
		logic        last;
		n = (bytes > 64) ? bytes / 32 : 1;
		len = (bytes > 64) ? 3'h3 : 3'(bytes / 8 - 1);
		cmd = stall ? agpr_pkg::CMD_READ_HI : agpr_pkg::CMD_READ;
		wq.delete();
		cq.delete();
		i = 0;
		while (rd_ready !== 1'b1 && i < 50) begin
			@(negedge clock);
			i++;
		end
		rd_addr = addr;
		rd_bytes = bytes;
		rd_stall_risk = stall;
		rd_valid = 1'b1;
		@(negedge clock);
		rd_valid = 1'b0;
		wait_cap(n > 4 ? 4 : n);
		if (n > 4) begin
			reply(1);
			wait_cap(n);
		end
		for (i = 0; i < n; i++) begin
			a = addr + 32'(32 * i);
			last = (i == n - 1) || (i == 3);
			check("wire piece", {3'h0, wq[i]}, {3'h0, a[31:3], len, cmd, last});
			check("captured", cq[i], {a[31:3], 3'h0, len, cmd, last});
		end
		check("piece count", 40'(cq.size()), 40'(n));
	endtask : run_job

	task pci_op;
		int i;
		i = 0;
		while (pci_ready !== 1'b1 && i < 50) begin
			@(negedge clock);
			i++;
		end
		pci_valid = 1'b1;
		@(negedge clock);
		pci_valid = 1'b0;
		repeat (20) @(negedge clock);
	endtask : pci_op

	task results;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		rd_valid = 1'b0;
		rd_addr = 32'h0000_0000;
		rd_bytes = 12'h000;
		rd_stall_risk = 1'b0;
		pci_valid = 1'b0;
		reply_complete = 1'b0;
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		// Single pieces at both length ends and both commands, PCI while one is open
		run_job(32'h0000_1000, 12'h040, 1'b0);
		pci_n = 0;
		pst_n = 0;
		pci_op();
		check("pci seen", 40'(pci_n), 40'h1);
		check("pci start", 40'(pst_n), 40'h1);
		reply(1);
		run_job(32'h0000_2008, 12'h008, 1'b1);
		reply(1);
		check("idle bus", {4'h0, agpr_if_i.addr_data_bus, agpr_if_i.cmd_byte_enable_n},
			{4'h0, agpr_pkg::AD_IDLE, agpr_pkg::CBE_IDLE});
		$display("test single done");
		// Split read filling the queue exactly
		run_job(32'h0002_0000, 12'h080, 1'b1);
		check("full", 40'(outstanding), 40'h4);
		reply(4);
		check("drained", 40'(outstanding), 40'h0);
		$display("test split done");
		// Five pieces: the fifth waits for a freed slot
		run_job(32'h0003_0040, 12'h0A0, 1'b0);
		check("refilled", 40'(outstanding), 40'h4);
		reply(4);
		check("empty", 40'(outstanding), 40'h0);
		$display("test refill done");
		results();
	end
endmodule : agpr_pipelined_read_requester_tb
